// ---- verilog/ics_top.v ----
/*
  Internal clock select: mode decode, base rate choice, glitch-free postscaler,
  quarter-rate clock output, trim register and accuracy flags, axi4-lite slave, interrupt.
  Assumes a free-running 250 mhz ref_clk_i, straps stable before reset release,
  and an outside master keeping axi4-lite rules.
*/
// The AXI4-Lite register port and the register addresses were left to the implementer.
`include "ics_defs.vh"
`default_nettype none

// Behaviour
// - four modes from one-time source select bits
// - eight frequencies from 500 kHz reference
// - postscaler divides base by 1,2,4,8
// - strap picks 16 MHz or 500 kHz base
// - high base codes: 16,8,4,2 MHz
// - low base codes: 500,250,125,62.5 kHz
// - divider select resets to binary 10
// - new divider takes effect without delay; here the mux waits until old and new clocks are both low
// - internal mode output: clock over four
// - internal io mode: both pins released
// - coarse flag set within 2 percent
// - fine flag set within 0.5 percent
// - six-bit signed trim, reset zero
// - trim moves gradually, no done flag
// - control layout: div 5:4, flags 3,2
// - trim adjusts both internal sources
// - trim monotonic: 011111 max, 100000 min
module ics_top #(
  parameter HI_HALF = `ICS_HI_HALF,
  parameter LO_HALF = `ICS_LO_HALF,
  parameter SETTLE_STEP = `ICS_SETTLE_STEP_CYC
) (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_n_i,
  // one-time configuration straps
  input wire [1:0] source_select_i,
  input wire base_rate_select_i,
  // external clock pin, sampled
  input wire clock_input_pin_i,
  // clock outputs
  output reg sys_clk_o,
  output reg clock_output_pin_o,
  output reg clock_output_oe_o,
  output reg clock_input_is_io_o,
  output reg [5:0] trim_value_o,
  // axi4-lite write
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // interrupt
  output reg irq_o
);

  // straps captured after reset release, never under the async reset
  reg strap_done_ff;
  reg [1:0] mode_ff;
  reg base_hi_ff;
  reg [1:0] strap_mode_meta_ff;
  reg [1:0] strap_mode_sync_ff;
  reg strap_base_meta_ff;
  reg strap_base_sync_ff;
  reg ext_meta_ff;
  reg ext_sync_ff;
  reg [1:0] divider_select_ff;
  reg [1:0] active_div_ff;
  reg [5:0] trim_ff;
  reg [8:0] base_cnt_ff;
  reg base_clk_ff;
  reg [2:0] post_ff;
  reg [1:0] quarter_ff;
  reg sys_prev_ff;
  reg [15:0] err_ff;
  reg [15:0] target_err_ff;
  reg [7:0] settle_ff;
  reg coarse_prev_ff;
  reg fine_prev_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [3:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;

  wire is_internal = mode_ff[1];
  wire coarse_flag = (err_ff <= `ICS_ERR_COARSE);
  wire fine_flag = (err_ff <= `ICS_ERR_FINE);
  wire [7:0] ctrl_rd = {2'h0, divider_select_ff, coarse_flag, fine_flag, 2'h0};

  // trim shifts the half period of whichever base runs; positive trim shortens it
  wire signed [8:0] hi_half_s = HI_HALF[8:0];
  wire signed [8:0] lo_half_s = LO_HALF[8:0];
  wire signed [8:0] trim_s = {{3{trim_ff[5]}}, trim_ff};
  wire signed [8:0] hi_adj = hi_half_s - (trim_s >>> 4);
  wire signed [8:0] lo_adj = lo_half_s - (trim_s >>> 2);
  // nine bits: the slow base at its slowest trim passes 255
  wire [8:0] half_raw = base_hi_ff ? hi_adj : lo_adj;
  wire [8:0] half_lim = (half_raw < 9'h001) ? 9'h001 : half_raw;

  // postscaler taps: code 11 = base, 10 = /2, 01 = /4, 00 = /8
  function tap;
    input [1:0] code;
    input b;
    input [2:0] p;
    begin
      case (code)
        2'h3: tap = b;
        2'h2: tap = p[0];
        2'h1: tap = p[1];
        default: tap = p[2];
      endcase
    end
  endfunction

  wire old_clk = tap(active_div_ff, base_clk_ff, post_ff);
  wire new_clk = tap(divider_select_ff, base_clk_ff, post_ff);
  wire int_clk = old_clk;
  wire sys_next = is_internal ? int_clk : ext_sync_ff;

  // strap pins pass two flops; no reset, so they track the pins while reset is low
  always @(posedge ref_clk_i) begin
    strap_mode_meta_ff <= source_select_i;
    strap_mode_sync_ff <= strap_mode_meta_ff;
    strap_base_meta_ff <= base_rate_select_i;
    strap_base_sync_ff <= strap_base_meta_ff;
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_done_ff <= 1'b0;
      mode_ff <= `ICS_MODE_INT_IO;
      base_hi_ff <= 1'b1;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      mode_ff <= strap_mode_sync_ff;
      base_hi_ff <= strap_base_sync_ff;
    end
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
    end else begin
      ext_meta_ff <= clock_input_pin_i;
      ext_sync_ff <= ext_meta_ff;
    end
  end

  // base oscillator model and binary postscaler chain, all from one source
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base_cnt_ff <= 9'h000;
      base_clk_ff <= 1'b0;
      post_ff <= 3'h0;
    end else if (base_cnt_ff + 9'h001 >= half_lim) begin
      base_cnt_ff <= 9'h000;
      base_clk_ff <= ~base_clk_ff;
      if (base_clk_ff) begin
        post_ff <= post_ff + 3'h1;
      end
    end else begin
      base_cnt_ff <= base_cnt_ff + 9'h001;
    end
  end

  // mux moves only when old and new clocks are both low: no runt, no start-up wait
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_div_ff <= `ICS_DIV_RESET;
    end else if (!old_clk && !new_clk) begin
      active_div_ff <= divider_select_ff;
    end
  end

  // outputs and quarter-rate divider
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_clk_o <= 1'b0;
      sys_prev_ff <= 1'b0;
      quarter_ff <= 2'h0;
      clock_output_pin_o <= 1'b0;
      clock_output_oe_o <= 1'b0;
      clock_input_is_io_o <= 1'b1;
      trim_value_o <= `ICS_TRIM_RESET;
    end else begin
      sys_clk_o <= sys_next;
      sys_prev_ff <= sys_next;
      if (sys_next && !sys_prev_ff) begin
        quarter_ff <= quarter_ff + 2'h1;
      end
      clock_output_pin_o <= quarter_ff[1];
      // ext io and internal io release the output pin
      clock_output_oe_o <= strap_done_ff && !mode_ff[0];
      clock_input_is_io_o <= is_internal;
      trim_value_o <= trim_ff;
    end
  end

  // accuracy model: error jumps on trim write, then decays step by step
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_ff <= `ICS_ERR_START;
      settle_ff <= 8'h00;
    end else if (aw_got_ff && w_got_ff && !s_axi_bvalid
                 && aw_addr_ff == `ICS_OFF_TRIM && w_strb_ff[0]) begin
      err_ff <= `ICS_ERR_START;
      settle_ff <= 8'h00;
    end else if (settle_ff + 8'h01 >= SETTLE_STEP[7:0]) begin
      settle_ff <= 8'h00;
      if (err_ff != 16'h0000) begin
        err_ff <= err_ff - 16'h0001;
      end
    end else begin
      settle_ff <= settle_ff + 8'h01;
    end
  end

  // axi4-lite slave; write fires when address and data both held
  wire wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
  wire rd_stat = s_axi_arvalid && s_axi_arready && s_axi_araddr == `ICS_OFF_IRQ_STAT;
  wire [2:0] ev_now = {coarse_flag & ~coarse_prev_ff, fine_flag & ~fine_prev_ff,
                       wr_fire & (aw_addr_ff == `ICS_OFF_TRIM)};

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ICS_RESP_OKAY;
      divider_select_ff <= `ICS_DIV_RESET;
      trim_ff <= `ICS_TRIM_RESET;
      irq_mask_ff <= 3'h0;
    end else begin
      s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ICS_RESP_OKAY;
        case (aw_addr_ff)
          `ICS_OFF_CTRL: begin
            if (w_strb_ff[0]) begin
              divider_select_ff <= w_data_ff[`ICS_DIV_HI:`ICS_DIV_LO];
            end
          end
          `ICS_OFF_TRIM: begin
            if (w_strb_ff[0]) begin
              trim_ff <= w_data_ff[5:0];
            end
          end
          `ICS_OFF_IRQ_STAT: begin
          end
          `ICS_OFF_IRQ_MASK: begin
            if (w_strb_ff[0]) begin
              irq_mask_ff <= w_data_ff[2:0];
            end
          end
          default: begin
            s_axi_bresp <= `ICS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ICS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ICS_RESP_OKAY;
        case (s_axi_araddr)
          `ICS_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_rd};
          `ICS_OFF_TRIM: s_axi_rdata <= {26'h0000000, trim_ff};
          `ICS_OFF_IRQ_STAT: s_axi_rdata <= {29'h00000000, irq_stat_ff};
          `ICS_OFF_IRQ_MASK: s_axi_rdata <= {29'h00000000, irq_mask_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ICS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky events; a new event in the clearing read's cycle survives
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      coarse_prev_ff <= 1'b0;
      fine_prev_ff <= 1'b0;
      irq_stat_ff <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      coarse_prev_ff <= coarse_flag;
      fine_prev_ff <= fine_flag;
      irq_stat_ff <= (rd_stat ? 3'h0 : irq_stat_ff) | ev_now;
      irq_o <= |(((rd_stat ? 3'h0 : irq_stat_ff) | ev_now) & irq_mask_ff);
    end
  end

endmodule
`default_nettype wire

// ---- verilog/ics_defs.vh ----
/*
  Constants of the internal clock select block: register map, fields, reset values, timing.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef ICS_DEFS_VH
`define ICS_DEFS_VH

// register byte offsets on the axi4-lite slave
`define ICS_OFF_CTRL 4'h0
`define ICS_OFF_TRIM 4'h4
`define ICS_OFF_IRQ_STAT 4'h8
`define ICS_OFF_IRQ_MASK 4'hC

// control register fields
`define ICS_DIV_HI 5
`define ICS_DIV_LO 4
`define ICS_COARSE_BIT 3
`define ICS_FINE_BIT 2
`define ICS_DIV_RESET 2'h2
`define ICS_TRIM_RESET 6'h00

// clock source modes from the one-time source select bits
`define ICS_MODE_EXT_OUT 2'h0
`define ICS_MODE_EXT_IO 2'h1
`define ICS_MODE_INT_OUT 2'h2
`define ICS_MODE_INT_IO 2'h3

// axi responses
`define ICS_RESP_OKAY 2'h0
`define ICS_RESP_SLVERR 2'h2

// ref clock 250 mhz; base half periods for 16 mhz-ish and 500 khz
`define ICS_REF_HZ 250000000
`define ICS_HI_HZ 16000000
`define ICS_LO_HZ 500000
`define ICS_HI_HALF (`ICS_REF_HZ / (2 * `ICS_HI_HZ))
`define ICS_LO_HALF (`ICS_REF_HZ / (2 * `ICS_LO_HZ))

// trim settling: accuracy error units, coarse 2 percent, fine 0.5 percent
`define ICS_ERR_COARSE 16'd200
`define ICS_ERR_FINE 16'd50
`define ICS_ERR_START 16'd1000
`define ICS_SETTLE_STEP_CYC 64

`endif

// ---- verification/ics_assertions.sv ----
/* port checker for ics_top: mode pins, trim reset, control read layout,
   output divide and pulse widths. assumes binding from the bench top. */
`default_nettype none
module ics_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // straps and clock pins
  input wire logic [1:0] source_select_i,
  input wire logic sys_clk_o,
  input wire logic clock_output_pin_o,
  input wire logic clock_output_oe_o,
  input wire logic clock_input_is_io_o,
  input wire logic [5:0] trim_value_o,
  // read channel
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [1:0] cnt_ff;
  logic [3:0] ra_ff;
  logic [2:0] nr_ff;
  logic seen_ff;
  logic sq_ff;
  logic oq_ff;
  wire rise = sys_clk_o & ~sq_ff;
  wire tog = clock_output_pin_o ^ oq_ff;
  // rises counted after a toggle, so output lag does not matter
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 2'h0;
      ra_ff <= 4'h0;
      nr_ff <= 3'h0;
      seen_ff <= 1'b0;
      sq_ff <= 1'b0;
      oq_ff <= 1'b0;
    end else begin
      if (cnt_ff != 2'h3)
        cnt_ff <= cnt_ff + 2'h1;
      if (s_axi_arvalid && s_axi_arready)
        ra_ff <= s_axi_araddr;
      sq_ff <= sys_clk_o;
      oq_ff <= clock_output_pin_o;
      seen_ff <= seen_ff | tog;
      if (tog)
        nr_ff <= 3'h0;
      else if (rise && nr_ff != 3'h7)
        nr_ff <= nr_ff + 3'h1;
    end
  end
  a_oe_by_mode: assert property (cnt_ff == 2'h3 |-> clock_output_oe_o == ~source_select_i[0])
    else $error("clock output enable wrong for mode");
  a_io_by_mode: assert property (cnt_ff == 2'h3 |-> clock_input_is_io_o == source_select_i[1])
    else $error("clock input release wrong for mode");
  a_cout_quarter: assert property (seen_ff && tog && clock_output_oe_o
    |-> nr_ff + {2'h0, rise} == 3'h2) else $error("clock output not a quarter");
  a_high_no_runt: assert property (cnt_ff == 2'h3 && source_select_i[1] && $rose(sys_clk_o)
    |-> sys_clk_o [*6]) else $error("short high pulse on system clock");
  a_low_no_runt: assert property (cnt_ff == 2'h3 && source_select_i[1] && $fell(sys_clk_o)
    |-> !sys_clk_o [*6]) else $error("short low pulse on system clock");
  a_trim_reset: assert property (cnt_ff == 2'h1 |-> trim_value_o == 6'h00)
    else $error("trim not zero after reset");
  a_ctrl_unused: assert property (s_axi_rvalid && ra_ff == 4'h0
    |-> (s_axi_rdata & 32'hFFFFFFC3) == 32'h0) else $error("control unused bits set");
  a_fine_coarse: assert property (s_axi_rvalid && ra_ff == 4'h0 && s_axi_rdata[2]
    |-> s_axi_rdata[3]) else $error("fine flag without coarse flag");
endmodule
`default_nettype wire

// ---- verification/internal_clock_select_tb.sv ----
/* bench for ics_top: axi4-lite master tasks, one task per scenario.
   assumes the checker compiled first and the defs header on the include path */
`include "ics_defs.vh"
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %0h want %0h", $time, (a), (b)); end end
module internal_clock_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HI = 7;
  localparam int LO = 250;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] source_select_i = 2'h2;
  logic base_rate_select_i = 1'b1;
  logic clock_input_pin_i = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic sys_clk_o, clock_output_pin_o, clock_output_oe_o, clock_input_is_io_o, irq_o;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [5:0] trim_value_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_errors = 0;
  int tests_run = 0;
  int ec = 0;
  // short settle step keeps the flag waits near two thousand cycles
  ics_top #(.HI_HALF(HI), .LO_HALF(LO), .SETTLE_STEP(2)) u_ics_top (
    .ref_clk_i, .reset_n_i, .source_select_i, .base_rate_select_i, .clock_input_pin_i,
    .sys_clk_o, .clock_output_pin_o, .clock_output_oe_o, .clock_input_is_io_o, .trim_value_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_o);
  initial forever #2 ref_clk_i = ~ref_clk_i;
  // external clock, period of ten ref cycles
  always @(posedge ref_clk_i) begin
    ec <= (ec == 4) ? 0 : ec + 1;
    if (ec == 4)
      clock_input_pin_i <= ~clock_input_pin_i;
  end
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end
  // straps change only while reset is low
  task automatic rst(input logic [1:0] m, input logic b);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    source_select_i <= m;
    base_rate_select_i <= b;
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta;
    bit tw;
    ta = 0;
    tw = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge ref_clk_i);
      if (s_axi_awready === 1'b1) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK({d & m, r}, {e, `ICS_RESP_OKAY})
  endtask
  // cycles between the third and fourth rise of the chosen clock
  task automatic per(input bit co, output int n);
    logic p;
    logic q;
    int k;
    p = 1'b1;
    k = 0;
    n = 0;
    while (k < 4) begin
      @(posedge ref_clk_i);
      q = co ? clock_output_pin_o : sys_clk_o;
      if (q && !p)
        k++;
      if (k == 3)
        n++;
      p = q;
    end
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    rdc(`ICS_OFF_CTRL, 32'hFFFFFFF3, 32'h20);
    rdc(`ICS_OFF_TRIM, 32'hFFFFFFFF, 32'h0);
    per(1'b0, n);
    `CHK(n, 4 * HI)
    wr(`ICS_OFF_CTRL, 32'hFF, `ICS_RESP_OKAY);
    rdc(`ICS_OFF_CTRL, 32'hFFFFFFF3, 32'h30);
    rd(4'h2, d, r);
    `CHK({d, r}, {32'h0, `ICS_RESP_SLVERR})
    wr(4'h6, 32'h1, `ICS_RESP_SLVERR);
  endtask
  task automatic t_codes(input logic b);
    int n;
    for (int c = 3; c >= 0; c--) begin
      wr(`ICS_OFF_CTRL, 32'(c << 4), `ICS_RESP_OKAY);
      per(1'b0, n);
      `CHK(n, 2 * (b ? HI : LO) * (8 >> c))
    end
  endtask
  task automatic t_trim(input logic b);
    logic [5:0] tv[3] = '{6'h1F, 6'h20, 6'h00};
    int n;
    int sh;
    wr(`ICS_OFF_CTRL, 32'h30, `ICS_RESP_OKAY);
    foreach (tv[i]) begin
      wr(`ICS_OFF_TRIM, {26'h0, tv[i]}, `ICS_RESP_OKAY);
      rdc(`ICS_OFF_TRIM, 32'hFFFFFFFF, {26'h0, tv[i]});
      `CHK(trim_value_o, tv[i])
      repeat (2100) @(posedge ref_clk_i);
      sh = b ? $signed(tv[i]) >>> 4 : $signed(tv[i]) >>> 2;
      per(1'b0, n);
      `CHK(n, 2 * ((b ? HI : LO) - sh))
    end
  endtask
  task automatic t_flags();
    logic [31:0] d;
    logic [1:0] r;
    wr(`ICS_OFF_IRQ_MASK, 32'h6, `ICS_RESP_OKAY);
    rd(`ICS_OFF_IRQ_STAT, d, r);
    wr(`ICS_OFF_TRIM, 32'h0, `ICS_RESP_OKAY);
    rdc(`ICS_OFF_CTRL, 32'hC, 32'h0);
    `CHK(irq_o, 1'b0)
    repeat (1700) @(posedge ref_clk_i);
    rdc(`ICS_OFF_CTRL, 32'hC, 32'h8);
    `CHK(irq_o, 1'b1)
    repeat (400) @(posedge ref_clk_i);
    rdc(`ICS_OFF_CTRL, 32'hC, 32'hC);
    rdc(`ICS_OFF_IRQ_STAT, 32'h7, 32'h7);
    repeat (3) @(posedge ref_clk_i);
    `CHK(irq_o, 1'b0)
    rdc(`ICS_OFF_IRQ_STAT, 32'h7, 32'h0);
  endtask
  task automatic t_modes();
    int n;
    for (int m = 0; m < 4; m++) begin
      rst(2'(m), 1'b1);
      repeat (3) @(posedge ref_clk_i);
      `CHK(clock_output_oe_o, !m[0])
      `CHK(clock_input_is_io_o, m[1])
      per(m == 2, n);
      `CHK(n, m == 2 ? 16 * HI : (m[1] ? 4 * HI : 10))
    end
  endtask
  initial begin
    rst(2'h2, 1'b1);
    t_regs();
    t_codes(1'b1);
    t_flags();
    t_trim(1'b1);
    t_modes();
    rst(2'h3, 1'b0);
    t_codes(1'b0);
    t_trim(1'b0);
    wrap_up();
  end
endmodule
bind ics_top ics_checker u_ics_checker (.ref_clk_i, .reset_n_i, .source_select_i, .sys_clk_o,
  .clock_output_pin_o, .clock_output_oe_o, .clock_input_is_io_o, .trim_value_o,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid);
`default_nettype wire
